// ==== verilog/rsv_pkg.sv ====
package rsv_pkg;
   // =========================================
   // timing
   localparam int CLK_MHZ = 125;
   localparam int SKEW_NS = 400;
   localparam int SKEW_CYC = (SKEW_NS * CLK_MHZ + 999) / 1000;
   localparam int MASK_US = 100;
   localparam int MASK_CYC = MASK_US * CLK_MHZ;
   localparam int LATCH_MS = 7;
   localparam int LATCH_CYC = LATCH_MS * 1000 * CLK_MHZ;
   localparam int STEP_CYC = 125;
   localparam logic [6:0] CODE_RESET = 7'h7F;
   localparam logic [6:0] CODE_NEAR_STEPS = 7'h10;
   localparam int SYNC_W = 10;
   // =========================================
   // states
   typedef enum logic [2:0] {
      RSV_OFF = 3'b000,
      RSV_SOFT = 3'b001,
      RSV_RUN = 3'b010,
      RSV_LATCH = 3'b011,
      RSV_OVP = 3'b100
   } rsv_state_t;
endpackage

// ==== verilog/rsv_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsv_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_ff;
   // =========================================
   // two stage synchroniser per bit
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
         if (reset) begin
            meta_ff[i] <= 1'b0;
            dout[i] <= 1'b0;
         end else if (clk_en) begin
            meta_ff[i] <= din[i];
            dout[i] <= meta_ff[i];
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/rsv_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsv_timer #(
   parameter int W = 20
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic start,
   input wire logic clear,
   input wire logic [W-1:0] load,
   output logic busy
);
   logic [W-1:0] cnt_ff;
   // =========================================
   // down counter; start wins over clear so a restart is never lost
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_ff <= '0;
      end else if (clk_en) begin
         if (start) begin
            cnt_ff <= load;
         end else if (clear) begin
            cnt_ff <= '0;
         end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
   assign busy = (cnt_ff != '0);
endmodule
`default_nettype wire

// ==== verilog/rsv_supervisor.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsv_supervisor #(
   parameter int LATCH_CYCLES = rsv_pkg::LATCH_CYC,
   parameter int MASK_CYCLES = rsv_pkg::MASK_CYC
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [6:0] target_voltage_code,
   input wire logic enable_in,
   input wire logic supply_ok_level,
   input wire logic supply_low_level,
   input wire logic window_ok,
   input wire logic overvoltage_trip,
   input wire logic reverse_below_190,
   input wire logic reverse_above_150,
   input wire logic reverse_above_50,
   input wire logic zero_cross,
   input wire logic overcurrent,
   input wire logic output_below_200,
   input wire logic soft_done,
   input wire logic pwm_on,
   output logic high_side_gate,
   output logic low_side_gate,
   output logic power_ok_flag,
   output logic ripple_pulse_mode,
   output logic current_limit_active,
   output logic loop_clamp_active,
   output logic softstart_discharge,
   output logic power_ok_delay_discharge,
   output logic reverse_voltage_guard,
   output logic latched_off,
   output logic [6:0] dac_code
);
   // =========================================
   // input synchronisers
   logic [6:0] code_s;
   logic [9:0] cmp_s;
   logic en_s, sok_s, slow_s, win_s, ov_s, rb190_s, ra150_s, ra50_s, zc_s, oc_s, lo200_s, sd_s, pwm_s;
   logic [2:0] sup_s;

   rsv_sync #(.W(7)) u_code_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .din(target_voltage_code),
      .dout(code_s)
   );
   rsv_sync #(.W(rsv_pkg::SYNC_W)) u_cmp_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .din({window_ok, overvoltage_trip, reverse_below_190, reverse_above_150, reverse_above_50,
            zero_cross, overcurrent, output_below_200, soft_done, pwm_on}),
      .dout(cmp_s)
   );
   rsv_sync #(.W(3)) u_sup_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .din({enable_in, supply_ok_level, supply_low_level}),
      .dout(sup_s)
   );
   assign {win_s, ov_s, rb190_s, ra150_s, ra50_s, zc_s, oc_s, lo200_s, sd_s, pwm_s} = cmp_s;
   assign {en_s, sok_s, slow_s} = sup_s;

   // =========================================
   // state and registers
   rsv_pkg::rsv_state_t state_ff, nxt_state;
   logic [6:0] seen_ff, final_ff, dac_ff;
   logic [7:0] skew_ff;
   logic [11:0] step_ff;
   logic pend_ff, down_ff, rvp_ff, ovp_rvp_ff, dcm_ff;
   logic hs_ff, ls_ff, pok_ff, rpm_ff, cl_ff, clamp_ff, ssd_ff, pgd_ff, lat_ff;

   // =========================================
   // decode: shutdown and code handling
   wire go_down = ~en_s | slow_s | ~sok_s;
   wire code_chg = (code_s != seen_ff);
   wire accept = pend_ff && (skew_ff == 8'h00) && !code_chg;
   wire active = (state_ff == rsv_pkg::RSV_SOFT) || (state_ff == rsv_pkg::RSV_RUN);
   wire stepping = (dac_ff != final_ff);
   wire step_now = active && stepping && (step_ff == 12'h000);
   // code value lower is higher voltage; downward move means code increasing
   wire [6:0] dac_gap = final_ff - dac_ff;
   wire dac_near = !down_ff || (dac_gap <= rsv_pkg::CODE_NEAR_STEPS);
   wire mask_busy;
   wire latch_busy;
   wire masked = mask_busy || !dac_near || (state_ff == rsv_pkg::RSV_SOFT);
   wire cl_fault = active && oc_s && !win_s && !masked;

   // mask timer restarted on every code change, before the skew wait accepts it, and held loaded while off
   rsv_timer #(.W(20)) u_mask_timer (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .start(code_chg || (state_ff == rsv_pkg::RSV_OFF)),
      .clear(1'b0),
      .load(20'(MASK_CYCLES)),
      .busy(mask_busy)
   );

   // latchoff delay; cleared when the fault goes away
   rsv_timer #(.W(24)) u_latch_timer (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .start(cl_fault && !latch_busy && !lat_ff),
      .clear(!cl_fault),
      .load(24'(LATCH_CYCLES)),
      .busy(latch_busy)
   );
   logic latch_busy_ff;
   // fire on the falling edge of the delay, only if the fault still stands
   wire latch_fire = latch_busy_ff && !latch_busy && cl_fault;

   // =========================================
   // next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rsv_pkg::RSV_OFF: begin
            if (!go_down) begin
               nxt_state = rsv_pkg::RSV_SOFT;
            end
         end
         rsv_pkg::RSV_SOFT: begin
            if (ov_s) begin
               nxt_state = rsv_pkg::RSV_OVP;
            end else if (sd_s && !stepping) begin
               nxt_state = rsv_pkg::RSV_RUN;
            end
         end
         rsv_pkg::RSV_RUN: begin
            if (ov_s) begin
               nxt_state = rsv_pkg::RSV_OVP;
            end else if (latch_fire) begin
               nxt_state = rsv_pkg::RSV_LATCH;
            end
         end
         rsv_pkg::RSV_LATCH: nxt_state = rsv_pkg::RSV_LATCH;
         rsv_pkg::RSV_OVP: nxt_state = rsv_pkg::RSV_OVP;
         default: nxt_state = rsv_pkg::RSV_OFF;
      endcase
      if (go_down) begin
         nxt_state = rsv_pkg::RSV_OFF;
      end
   end

   // =========================================
   // gate decode
   logic nxt_hs, nxt_ls;
   always_comb begin
      nxt_hs = 1'b0;
      nxt_ls = 1'b0;
      if (state_ff == rsv_pkg::RSV_OVP) begin
         nxt_ls = !ovp_rvp_ff;
      end else if (active && !rvp_ff) begin
         nxt_hs = pwm_s;
         nxt_ls = !pwm_s && !dcm_ff;
      end
   end

   // =========================================
   // main sequencing registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_ff <= rsv_pkg::RSV_OFF;
         seen_ff <= rsv_pkg::CODE_RESET;
         final_ff <= rsv_pkg::CODE_RESET;
         dac_ff <= rsv_pkg::CODE_RESET;
         skew_ff <= 8'h00;
         step_ff <= 12'h000;
         pend_ff <= 1'b0;
         down_ff <= 1'b0;
         latch_busy_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         seen_ff <= code_s;
         latch_busy_ff <= latch_busy;
         // restart the skew wait on every edge of the code
         if (code_chg) begin
            pend_ff <= 1'b1;
            skew_ff <= 8'(rsv_pkg::SKEW_CYC);
         end else if (skew_ff != 8'h00) begin
            skew_ff <= skew_ff - 8'h01;
         end else if (accept) begin
            pend_ff <= 1'b0;
            down_ff <= (code_s > dac_ff);
            final_ff <= code_s;
         end
         // step one code per interval
         if (state_ff == rsv_pkg::RSV_OFF) begin
            dac_ff <= final_ff;
            step_ff <= 12'h000;
         end else if (step_now) begin
            dac_ff <= (final_ff > dac_ff) ? dac_ff + 7'h01 : dac_ff - 7'h01;
            step_ff <= 12'(rsv_pkg::STEP_CYC);
         end else if (step_ff != 12'h000) begin
            step_ff <= step_ff - 12'h001;
         end
      end
   end

   // =========================================
   // protection and output registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rvp_ff <= 1'b0;
         ovp_rvp_ff <= 1'b0;
         dcm_ff <= 1'b0;
         hs_ff <= 1'b0;
         ls_ff <= 1'b0;
         pok_ff <= 1'b0;
         rpm_ff <= 1'b0;
         cl_ff <= 1'b0;
         clamp_ff <= 1'b0;
         ssd_ff <= 1'b1;
         pgd_ff <= 1'b1;
         lat_ff <= 1'b0;
      end else if (clk_en) begin
         // hysteresis: set below -190, release above -150
         if (rb190_s) begin
            rvp_ff <= 1'b1;
         end else if (ra150_s) begin
            rvp_ff <= 1'b0;
         end
         // in overvoltage latch release only above +50
         if (rb190_s) begin
            ovp_rvp_ff <= 1'b1;
         end else if (ra50_s) begin
            ovp_rvp_ff <= 1'b0;
         end
         // zero cross without overcurrent ends low side conduction until next high pulse
         if (pwm_s) begin
            dcm_ff <= 1'b0;
         end else if (zc_s && !oc_s) begin
            dcm_ff <= 1'b1;
         end
         hs_ff <= nxt_hs;
         ls_ff <= nxt_ls;
         pok_ff <= active && !masked && win_s && !go_down;
         rpm_ff <= (state_ff == rsv_pkg::RSV_RUN) && !oc_s && !mask_busy && !stepping;
         cl_ff <= active && oc_s;
         clamp_ff <= (state_ff == rsv_pkg::RSV_SOFT) && lo200_s;
         ssd_ff <= (state_ff == rsv_pkg::RSV_OFF);
         pgd_ff <= (state_ff == rsv_pkg::RSV_OFF);
         lat_ff <= (nxt_state == rsv_pkg::RSV_LATCH) || (nxt_state == rsv_pkg::RSV_OVP);
      end
   end

   assign high_side_gate = hs_ff;
   assign low_side_gate = ls_ff;
   assign power_ok_flag = pok_ff;
   assign ripple_pulse_mode = rpm_ff;
   assign current_limit_active = cl_ff;
   assign loop_clamp_active = clamp_ff;
   assign softstart_discharge = ssd_ff;
   assign power_ok_delay_discharge = pgd_ff;
   assign reverse_voltage_guard = rvp_ff;
   assign latched_off = lat_ff;
   assign dac_code = dac_ff;
endmodule
`default_nettype wire

// ==== tb/rsv_supervisor_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// port checks for the supervisor
module rsv_supervisor_asserts #(
   parameter int LATCH_CYCLES = 100,
   parameter int MASK_CYCLES = 50
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [6:0] target_voltage_code,
   input wire logic enable_in,
   input wire logic supply_ok_level,
   input wire logic supply_low_level,
   input wire logic window_ok,
   input wire logic overvoltage_trip,
   input wire logic reverse_below_190,
   input wire logic reverse_above_50,
   input wire logic overcurrent,
   input wire logic high_side_gate,
   input wire logic low_side_gate,
   input wire logic power_ok_flag,
   input wire logic ripple_pulse_mode,
   input wire logic softstart_discharge,
   input wire logic power_ok_delay_discharge,
   input wire logic latched_off,
   input wire logic [6:0] dac_code
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // supply and enable good; inputs lag two sync stages, hence the repeats
   wire logic live;
   assign live = clk_en && enable_in && supply_ok_level && !supply_low_level;
   property p_overlap; !(high_side_gate && low_side_gate); endproperty
   a_overlap: assert property (p_overlap) else $error("both gates on");
   property p_window; (clk_en && !window_ok) [*4] |-> !power_ok_flag; endproperty
   a_window: assert property (p_window) else $error("flag high out of window");
   property p_off; (clk_en && !enable_in) [*6] |-> !high_side_gate && !low_side_gate && !power_ok_flag
      && softstart_discharge && power_ok_delay_discharge && !latched_off; endproperty
   a_off: assert property (p_off) else $error("shutdown outputs wrong");
   property p_crowbar; (live && overvoltage_trip && reverse_above_50 && !reverse_below_190) [*6]
      |-> low_side_gate && !high_side_gate; endproperty
   a_crowbar: assert property (p_crowbar) else $error("no crowbar");
   property p_hold; live [*6] ##0 latched_off |=> latched_off; endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_reverse; (clk_en && reverse_below_190) [*6] |-> !high_side_gate && !low_side_gate; endproperty
   a_reverse: assert property (p_reverse) else $error("gate on in reverse");
   property p_overload; (live && overcurrent) [*6] |-> !ripple_pulse_mode; endproperty
   a_overload: assert property (p_overload) else $error("ripple mode in overload");
   property p_mask; live && $changed(target_voltage_code) |-> ##[1:60] (!power_ok_flag && !ripple_pulse_mode);
   endproperty
   a_mask: assert property (p_mask) else $error("no mask after code change");
   property p_step; live [*4] ##0 $changed(dac_code)
      |-> (dac_code - $past(dac_code)) == 7'h01 || (dac_code - $past(dac_code)) == 7'h7F; endproperty
   a_step: assert property (p_step) else $error("dac jumped");
   c_ok: cover property (power_ok_flag);
   c_ovp: cover property (latched_off && overvoltage_trip);
   c_clear: cover property ($fell(latched_off));
endmodule
bind rsv_supervisor rsv_supervisor_asserts #(.LATCH_CYCLES(LATCH_CYCLES), .MASK_CYCLES(MASK_CYCLES))
   rsv_supervisor_asserts_i (.*);
`default_nettype wire

// ==== tb/rsv_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// host side: voltage code and enable
module rsv_host_model (
   input wire logic ref_clk,
   output logic enable_in,
   output logic [6:0] target_voltage_code
);
   // grounded until the bench brings the rail up
   initial begin
      enable_in = 1'h0;
      target_voltage_code = 7'h00;
   end
   // bits land one at a time, gap cycles apart, like a skewed bus
   task automatic set_code(input logic [6:0] code, input int gap);
      for (int b = 0; b < 7; b++) begin
         repeat (gap) @(posedge ref_clk);
         #1 target_voltage_code[b] = code[b];
      end
   endtask
   task automatic set_enable(input logic v);
      @(posedge ref_clk);
      #1 enable_in = v;
   endtask
endmodule
`default_nettype wire

// ==== tb/rsv_supervisor_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// =====
// supervisor bench
module rsv_supervisor_bench;
   logic ref_clk = 1'h0, reset = 1'h1, clk_en = 1'h1;
   logic supply_ok_level = 1'h0, supply_low_level = 1'h0, window_ok = 1'h1, overvoltage_trip = 1'h0;
   logic reverse_below_190 = 1'h0, reverse_above_150 = 1'h1, reverse_above_50 = 1'h1, zero_cross = 1'h0;
   logic overcurrent = 1'h0, output_below_200 = 1'h0, soft_done = 1'h1, pwm_on = 1'h0;
   logic high_side_gate, low_side_gate, power_ok_flag, ripple_pulse_mode, current_limit_active;
   logic loop_clamp_active, softstart_discharge, power_ok_delay_discharge, reverse_voltage_guard, latched_off;
   logic [6:0] dac_code;
   wire logic enable_in;
   wire logic [6:0] target_voltage_code;
   int n_mismatch = 0;
   int samples_checked = 0;
   // short counts keep the run small
   rsv_supervisor #(.LATCH_CYCLES(100), .MASK_CYCLES(50)) rsv_supervisor_i (.*);
   rsv_host_model rsv_host_model_i (.*);
   // clock; modulator demand toggles away from the sampling edge
   always #4 ref_clk = ~ref_clk;
   always #40 begin
      pwm_on = ~pwm_on;
      zero_cross = ~pwm_on;
   end
   // =====
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_dac(input logic [6:0] c);
      for (int i = 0; i < 4000 && dac_code !== c; i++) tick(1);
      chk(dac_code, c);
   endtask
   // restart after a latch or shutdown waits out the mask; the dac takes the final code while off, so no ramp
   task automatic wait_ok();
      for (int i = 0; i < 6000 && power_ok_flag !== 1'h1; i++) tick(1);
      chk(power_ok_flag, 7'h01);
   endtask
   task automatic report_and_stop();
      $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic reverse_in(input logic below, input logic a150, input logic a50);
      reverse_below_190 = below;
      reverse_above_150 = a150;
      reverse_above_50 = a50;
      tick(6);
   endtask
   // =====
   // scenarios
   task automatic t_start();
      chk({high_side_gate, low_side_gate, power_ok_flag, softstart_discharge}, 7'h01);
      chk(dac_code, 7'h7F);
      reset = 1'h0;
      supply_ok_level = 1'h1;
      rsv_host_model_i.set_code(7'h70, 1);
      rsv_host_model_i.set_enable(1'h1);
      tick(10);
      chk(power_ok_flag, 7'h00);
      wait_dac(7'h70);
      wait_ok();
   endtask
   task automatic t_codes();
      rsv_host_model_i.set_code(7'h60, 5);
      tick(10);
      chk({power_ok_flag, ripple_pulse_mode}, 7'h00);
      wait_dac(7'h60);
      wait_ok();
      rsv_host_model_i.set_code(7'h78, 1);
      wait_dac(7'h64);
      chk(power_ok_flag, 7'h00);
      wait_dac(7'h78);
      wait_ok();
      window_ok = 1'h0;
      tick(6);
      chk(power_ok_flag, 7'h00);
      window_ok = 1'h1;
      tick(6);
      chk(power_ok_flag, 7'h01);
      chk(ripple_pulse_mode, 7'h01);
      // clock enable low: state frozen, window loss not seen
      clk_en = 1'h0;
      window_ok = 1'h0;
      tick(10);
      chk(power_ok_flag, 7'h01);
      clk_en = 1'h1;
      tick(6);
      chk(power_ok_flag, 7'h00);
      window_ok = 1'h1;
      tick(6);
      chk(power_ok_flag, 7'h01);
   endtask
   task automatic t_overload();
      overcurrent = 1'h1;
      tick(6);
      chk({ripple_pulse_mode, current_limit_active}, 7'h01);
      window_ok = 1'h0;
      tick(60);
      chk(latched_off, 7'h00);
      tick(60);
      chk(latched_off, 7'h01);
      overcurrent = 1'h0;
      window_ok = 1'h1;
      tick(10);
      chk(latched_off, 7'h01);
      rsv_host_model_i.set_enable(1'h0);
      rsv_host_model_i.set_enable(1'h1);
      tick(10);
      chk(latched_off, 7'h00);
      wait_ok();
   endtask
   task automatic t_faults();
      overvoltage_trip = 1'h1;
      tick(6);
      chk({low_side_gate, high_side_gate}, 7'h02);
      overvoltage_trip = 1'h0;
      tick(6);
      chk({latched_off, low_side_gate}, 7'h03);
      reverse_in(1'h1, 1'h0, 1'h0);
      chk(low_side_gate, 7'h00);
      reverse_in(1'h0, 1'h1, 1'h0);
      chk(low_side_gate, 7'h00);
      reverse_in(1'h0, 1'h1, 1'h1);
      chk(low_side_gate, 7'h01);
      rsv_host_model_i.set_enable(1'h0);
      rsv_host_model_i.set_enable(1'h1);
      wait_ok();
      reverse_in(1'h1, 1'h0, 1'h0);
      chk({high_side_gate, low_side_gate, reverse_voltage_guard}, 7'h01);
      reverse_in(1'h0, 1'h0, 1'h0);
      chk(reverse_voltage_guard, 7'h01);
      reverse_in(1'h0, 1'h1, 1'h1);
      chk(reverse_voltage_guard, 7'h00);
   endtask
   task automatic t_uvlo();
      supply_low_level = 1'h1;
      tick(6);
      chk({high_side_gate, low_side_gate, power_ok_flag}, 7'h00);
      chk({softstart_discharge, power_ok_delay_discharge}, 7'h03);
      soft_done = 1'h0;
      output_below_200 = 1'h1;
      supply_low_level = 1'h0;
      tick(20);
      chk(loop_clamp_active, 7'h01);
      output_below_200 = 1'h0;
      soft_done = 1'h1;
      wait_ok();
      // supply falls under the ok level alone
      supply_ok_level = 1'h0;
      tick(6);
      chk({high_side_gate, low_side_gate, power_ok_flag}, 7'h00);
      supply_ok_level = 1'h1;
      wait_ok();
   endtask
   // watchdog well past the expected run length
   initial begin
      #(80000 * 8);
      n_mismatch++;
      report_and_stop();
   end
   // main sequence, reset held for five cycles
   initial begin
      tick(5);
      t_start();
      t_codes();
      t_overload();
      t_faults();
      t_uvlo();
      report_and_stop();
   end
endmodule
`default_nettype wire
